/* hdl/wkt_top.sv */
// Wakeup interval timer and watchdog with APB register access
`timescale 1ns/1ps
module wkt_top #(
  parameter int WDT_BASE_CYCLES = wkt_pkg::WDT_BASE_CYCLES
) (
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wkt_pkg::ADDR_W-1:0] paddr,
  input wire logic [wkt_pkg::DATA_W-1:0] pwdata,
  output logic [wkt_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Count clock pins
  input wire logic internal_rc_clock,
  input wire logic xtal_clock,
  // Events
  output logic irq,
  output logic watchdog_overflow
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic idx_hit(
    input logic [wkt_pkg::ADDR_W-1:0] addr,
    input logic [7:0] idx
  );
    idx_hit = (addr == {2'b00, idx, 2'b00});
  endfunction : idx_hit

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [wkt_pkg::DATA_W-1:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic wdt_ovf_q;
  logic [wkt_pkg::WDT_CODE_W-1:0] wdt_period_q;
  logic [wkt_pkg::REG_W-1:0] wdt_key_q;
  logic [wkt_pkg::CFG_W-1:0] cfg_q;
  logic [wkt_pkg::CFG_W-1:0] cfg_d;
  logic [wkt_pkg::REG_W-1:0] tgt_high_q;
  logic [wkt_pkg::REG_W-1:0] tgt_low_q;
  logic [wkt_pkg::STAT_W-1:0] stat_q;
  logic [wkt_pkg::STAT_W-1:0] stat_d;
  logic [wkt_pkg::STAT_W-1:0] mask_q;

  // ----------------------------------------------------------------
  // Pin synchronisers, a rise counts once stages two and three agree
  // ----------------------------------------------------------------
  wire logic [1:0] pin_raw = {xtal_clock, internal_rc_clock};
  logic [1:0] pin_tick;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      logic [wkt_pkg::SYNC_STAGES-1:0] stage_q;
      logic level_q;
      logic tick_q;
      wire logic agree = (stage_q[1] == stage_q[2]);
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          stage_q <= '0;
          level_q <= 1'b0;
          tick_q <= 1'b0;
        end else if (clk_en) begin
          stage_q <= {stage_q[1:0], pin_raw[gi]};
          tick_q <= agree & stage_q[2] & ~level_q;
          if (agree) begin
            level_q <= stage_q[2];
          end
        end
      end
      assign pin_tick[gi] = tick_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // APB access decode
  // ----------------------------------------------------------------
  // One wait state: pready rises a cycle into the access phase
  wire logic acc_wait = psel & penable & ~pready_q;
  wire logic acc_done = psel & penable & pready_q;
  wire logic wr_fire = acc_done & pwrite;

  wire logic hit_mask = idx_hit(paddr, wkt_pkg::IDX_IRQ_MASK);
  wire logic hit_stat = idx_hit(paddr, wkt_pkg::IDX_IRQ_STATUS);
  wire logic hit_wper = idx_hit(paddr, wkt_pkg::IDX_WDT_PERIOD);
  wire logic hit_wkey = idx_hit(paddr, wkt_pkg::IDX_WDT_KEY);
  wire logic hit_cfg = idx_hit(paddr, wkt_pkg::IDX_TMR_CFG);
  wire logic hit_th = idx_hit(paddr, wkt_pkg::IDX_TGT_HIGH);
  wire logic hit_tl = idx_hit(paddr, wkt_pkg::IDX_TGT_LOW);
  wire logic hit_cl = idx_hit(paddr, wkt_pkg::IDX_CNT_LOW);
  wire logic hit_ch = idx_hit(paddr, wkt_pkg::IDX_CNT_HIGH);
  wire logic hit_any = hit_mask | hit_stat | hit_wper | hit_wkey |
    hit_cfg | hit_th | hit_tl | hit_cl | hit_ch;
  // Count registers are read only, a write to them is an error
  wire logic bad_acc = ~hit_any | (pwrite & (hit_cl | hit_ch));

  wire logic wr_mask = wr_fire & hit_mask;
  wire logic wr_stat = wr_fire & hit_stat;
  wire logic wr_wper = wr_fire & hit_wper;
  wire logic wr_wkey = wr_fire & hit_wkey;
  wire logic wr_cfg = wr_fire & hit_cfg;
  wire logic wr_th = wr_fire & hit_th;
  wire logic wr_tl = wr_fire & hit_tl;

  // ----------------------------------------------------------------
  // Timer control fields
  // ----------------------------------------------------------------
  wire logic count_enable = cfg_q[wkt_pkg::CFG_ENABLE_BIT];
  wire logic auto_reload_select = cfg_q[wkt_pkg::CFG_RELOAD_BIT];
  wire logic count_clock_select = cfg_q[wkt_pkg::CFG_CLKSEL_BIT];
  wire logic count_step_mode = cfg_q[wkt_pkg::CFG_STEP_BIT];
  wire logic [wkt_pkg::TGT_W-1:0] target = {tgt_high_q, tgt_low_q};
  wire logic new_enable = pwdata[wkt_pkg::CFG_ENABLE_BIT];
  wire logic restart_cfg = wr_cfg & new_enable & count_enable;
  wire logic restart_tgt = (wr_th | wr_tl) & count_enable;
  wire logic tmr_restart = restart_cfg | restart_tgt;
  wire logic watchdog_running = (wdt_key_q != wkt_pkg::WDT_OFF_KEY);
  wire logic wdt_restart = wr_wper | wr_wkey;

  logic interval_done;
  logic wdt_event;
  logic [wkt_pkg::TGT_W-1:0] interval_count;

  // ----------------------------------------------------------------
  // Units
  // ----------------------------------------------------------------
  wkt_interval #(
    .TARGET_W(wkt_pkg::TGT_W),
    .STEP_W(wkt_pkg::LONG_STEP_W)
  ) u_interval (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .count_enable(count_enable),
    .auto_reload_select(auto_reload_select),
    .count_clock_select(count_clock_select),
    .count_step_mode(count_step_mode),
    .restart(tmr_restart),
    .target(target),
    .rc_tick(pin_tick[0]),
    .xtal_tick(pin_tick[1]),
    .done(interval_done),
    .count(interval_count)
  );

  wkt_watchdog #(
    .CNT_W(wkt_pkg::WDT_CNT_W),
    .BASE_CYCLES(WDT_BASE_CYCLES)
  ) u_watchdog (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .running(watchdog_running),
    .restart(wdt_restart),
    .watchdog_period_code(wdt_period_q),
    .overflow(wdt_event)
  );

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  // A software write beats the hardware clear of the enable bit
  always_comb begin
    cfg_d = cfg_q;
    if (wr_cfg) begin
      cfg_d = pwdata[wkt_pkg::CFG_W-1:0];
    end else if (interval_done && !auto_reload_select) begin
      cfg_d[wkt_pkg::CFG_ENABLE_BIT] = 1'b0;
    end
  end

  // Hardware set wins over any clear in the same cycle
  wire logic [wkt_pkg::STAT_W-1:0] stat_set = {wdt_event, interval_done};
  wire logic [wkt_pkg::STAT_W-1:0] stat_w1c =
    wr_stat ? pwdata[wkt_pkg::STAT_W-1:0] : '0;
  wire logic [wkt_pkg::STAT_W-1:0] stat_side = {wr_wper, wr_cfg};

  always_comb begin
    stat_d = stat_set | (stat_q & ~(stat_w1c | stat_side));
  end

  wire logic irq_d = |(stat_d & mask_q);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire logic [wkt_pkg::REG_W-1:0] rd_byte =
    hit_mask ? {6'h00, mask_q} :
    hit_stat ? {6'h00, stat_q} :
    hit_wper ? {5'h00, wdt_period_q} :
    hit_wkey ? wdt_key_q :
    hit_cfg ? {4'h0, cfg_q} :
    hit_th ? tgt_high_q :
    hit_tl ? tgt_low_q :
    hit_cl ? interval_count[7:0] :
    hit_ch ? interval_count[15:8] : 8'h00;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else if (clk_en) begin
      pready_q <= acc_wait;
      pslverr_q <= acc_wait & bad_acc;
      if (acc_wait && !pwrite) begin
        prdata_q <= {24'h000000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wdt_period_q <= wkt_pkg::RST_REG[wkt_pkg::WDT_CODE_W-1:0];
      wdt_key_q <= wkt_pkg::RST_REG;
      tgt_high_q <= wkt_pkg::RST_REG;
      tgt_low_q <= wkt_pkg::RST_REG;
      mask_q <= wkt_pkg::RST_REG[wkt_pkg::STAT_W-1:0];
    end else if (clk_en) begin
      if (wr_wper) begin
        wdt_period_q <= pwdata[wkt_pkg::WDT_CODE_W-1:0];
      end
      if (wr_wkey) begin
        wdt_key_q <= pwdata[wkt_pkg::REG_W-1:0];
      end
      if (wr_th) begin
        tgt_high_q <= pwdata[wkt_pkg::REG_W-1:0];
      end
      if (wr_tl) begin
        tgt_low_q <= pwdata[wkt_pkg::REG_W-1:0];
      end
      if (wr_mask) begin
        mask_q <= pwdata[wkt_pkg::STAT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cfg_q <= wkt_pkg::RST_REG[wkt_pkg::CFG_W-1:0];
      stat_q <= wkt_pkg::RST_REG[wkt_pkg::STAT_W-1:0];
      irq_q <= 1'b0;
      wdt_ovf_q <= 1'b0;
    end else if (clk_en) begin
      cfg_q <= cfg_d;
      stat_q <= stat_d;
      irq_q <= irq_d;
      wdt_ovf_q <= wdt_event;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign watchdog_overflow = wdt_ovf_q;

endmodule : wkt_top

/* hdl/wkt_pkg.sv */
// Shared constants and types for the wakeup timer and watchdog block
package wkt_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_IRQ_MASK = 8'h80;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h85;
  localparam logic [7:0] IDX_WDT_PERIOD = 8'h91;
  localparam logic [7:0] IDX_WDT_KEY = 8'h92;
  localparam logic [7:0] IDX_TMR_CFG = 8'h93;
  localparam logic [7:0] IDX_TGT_HIGH = 8'h94;
  localparam logic [7:0] IDX_TGT_LOW = 8'h95;
  localparam logic [7:0] IDX_CNT_LOW = 8'ha8;
  localparam logic [7:0] IDX_CNT_HIGH = 8'ha9;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_RELOAD_BIT = 1;
  localparam int CFG_CLKSEL_BIT = 2;
  localparam int CFG_STEP_BIT = 3;
  localparam int CFG_W = 4;
  localparam int WDT_CODE_W = 3;
  localparam int STAT_TMR_BIT = 0;
  localparam int STAT_WDT_BIT = 1;
  localparam int STAT_W = 2;

  // ----------------------------------------------------------------
  // Reset values and key
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_REG = 8'h00;
  localparam logic [REG_W-1:0] WDT_OFF_KEY = 8'h55;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 50000000;
  localparam int WDT_BASE_MS = 18;
  localparam int WDT_BASE_CYCLES = WDT_BASE_MS * (SYS_CLK_HZ / 1000);
  localparam int WDT_CNT_W = 27;
  localparam int TGT_W = 16;
  localparam int LONG_STEP_W = 16;
  localparam int SYNC_STAGES = 3;

  typedef enum logic {TMR_IDLE, TMR_RUN} wkt_tmr_state_type;

endpackage : wkt_pkg

/* hdl/wkt_interval.sv */
// Interval counter: step prescaler, target compare and reload
`timescale 1ns/1ps
module wkt_interval #(
  parameter int TARGET_W = wkt_pkg::TGT_W,
  parameter int STEP_W = wkt_pkg::LONG_STEP_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // Control
  input wire logic count_enable,
  input wire logic auto_reload_select,
  input wire logic count_clock_select,
  input wire logic count_step_mode,
  input wire logic restart,
  input wire logic [TARGET_W-1:0] target,
  // Source ticks
  input wire logic rc_tick,
  input wire logic xtal_tick,
  // Status
  output logic done,
  output logic [TARGET_W-1:0] count
);

  wkt_pkg::wkt_tmr_state_type state_q;
  logic [STEP_W-1:0] prescale_q;
  logic [TARGET_W-1:0] count_q;
  logic done_q;

  wire logic src_tick = count_clock_select ? xtal_tick : rc_tick;
  wire logic long_wrap = (prescale_q == {STEP_W{1'b1}});
  wire logic step = src_tick & (count_step_mode ? long_wrap : 1'b1);
  wire logic [TARGET_W-1:0] count_inc = count_q + 1'b1;
  wire logic hit = step & (count_inc == target);

  assign done = done_q;
  assign count = count_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= wkt_pkg::TMR_IDLE;
      prescale_q <= '0;
      count_q <= '0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      case (state_q)
        wkt_pkg::TMR_IDLE: begin
          // Hold off while the enable bit clears after a manual finish
          if (count_enable && !done_q) begin
            state_q <= wkt_pkg::TMR_RUN;
            prescale_q <= '0;
            count_q <= '0;
          end
        end
        wkt_pkg::TMR_RUN: begin
          if (!count_enable) begin
            state_q <= wkt_pkg::TMR_IDLE;
          end else if (restart) begin
            prescale_q <= '0;
            count_q <= '0;
          end else if (src_tick) begin
            prescale_q <= count_step_mode ? prescale_q + 1'b1 : '0;
            if (hit) begin
              done_q <= 1'b1;
              count_q <= '0;
              if (!auto_reload_select) begin
                state_q <= wkt_pkg::TMR_IDLE;
              end
            end else if (step) begin
              count_q <= count_inc;
            end
          end
        end
        default: begin
          state_q <= wkt_pkg::TMR_IDLE;
        end
      endcase
    end
  end

endmodule : wkt_interval

/* hdl/wkt_watchdog.sv */
// Watchdog period counter with selectable overflow length
`timescale 1ns/1ps
module wkt_watchdog #(
  parameter int CNT_W = wkt_pkg::WDT_CNT_W,
  parameter int BASE_CYCLES = wkt_pkg::WDT_BASE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // Control
  input wire logic running,
  input wire logic restart,
  input wire logic [wkt_pkg::WDT_CODE_W-1:0] watchdog_period_code,
  // Status
  output logic overflow
);

  logic [CNT_W-1:0] count_q;
  logic overflow_q;

  // Code 0 is the base period, each step up doubles it
  wire logic [CNT_W-1:0] period =
    CNT_W'(BASE_CYCLES) << watchdog_period_code;
  wire logic at_end = (count_q >= period - 1'b1);

  assign overflow = overflow_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      count_q <= '0;
      overflow_q <= 1'b0;
    end else if (clk_en) begin
      overflow_q <= 1'b0;
      if (!running || restart) begin
        count_q <= '0;
      end else if (at_end) begin
        count_q <= '0;
        overflow_q <= 1'b1;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end

endmodule : wkt_watchdog

/* verification/wkt_assertions.sv */
// Port-level checks for the wakeup timer and watchdog block
`timescale 1ns/1ps
module wkt_assertions #(
  parameter int WDT_BASE_CYCLES = wkt_pkg::WDT_BASE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wkt_pkg::ADDR_W-1:0] paddr,
  input wire logic [wkt_pkg::DATA_W-1:0] pwdata,
  input wire logic [wkt_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Count clock pins and events
  input wire logic internal_rc_clock,
  input wire logic xtal_clock,
  input wire logic irq,
  input wire logic watchdog_overflow
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  wire logic [7:0] reg_idx = paddr[9:2];
  wire logic mapped = paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00 &&
    (reg_idx inside {wkt_pkg::IDX_IRQ_MASK, wkt_pkg::IDX_IRQ_STATUS,
    wkt_pkg::IDX_WDT_PERIOD, wkt_pkg::IDX_WDT_KEY, wkt_pkg::IDX_TMR_CFG,
    wkt_pkg::IDX_TGT_HIGH, wkt_pkg::IDX_TGT_LOW, wkt_pkg::IDX_CNT_LOW,
    wkt_pkg::IDX_CNT_HIGH});
  // Cycles since the last overflow; key writes only stretch the gap
  int gap_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_b || watchdog_overflow) gap_q <= 0;
    else if (clk_en) gap_q <= gap_q + 1;
  end

  chk_ready_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("no ready one cycle into the access phase");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_ready_cause: assert property (!(psel && penable) |=> !pready)
    else $error("ready without an access phase");
  chk_err_count: assert property (
    pready && pwrite && paddr[11:3] == 9'h054 |-> pslverr)
    else $error("write to count register accepted");
  chk_err_unmap: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access accepted");
  chk_rd_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  chk_wdog_pulse: assert property (
    watchdog_overflow |=> !watchdog_overflow)
    else $error("overflow pulse longer than one cycle");
  chk_wdog_gap: assert property (
    watchdog_overflow |-> gap_q >= WDT_BASE_CYCLES - 2)
    else $error("overflow sooner than shortest period");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !rst_b |=> !pready && !irq && !watchdog_overflow)
    else $error("output active after reset");
endmodule : wkt_assertions

bind wkt_top wkt_assertions #(.WDT_BASE_CYCLES(WDT_BASE_CYCLES)) chk_u (
  .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .internal_rc_clock(internal_rc_clock), .xtal_clock(xtal_clock),
  .irq(irq), .watchdog_overflow(watchdog_overflow));

/* verification/testbench.sv */
// Self-checking bench for the wakeup timer and watchdog block
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Stimulus and design
  // ----------------------------------------------------------------
  localparam int BASE = 100;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [wkt_pkg::ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, watchdog_overflow;
  logic rc_pin = 1'b0;
  logic xt_pin = 1'b0;
  int cyc = 0;
  int error_cnt = 0;
  int n_tests = 0;
  int mdl [int];

  always #10 clk_sys = ~clk_sys;
  // Count clocks with periods of 8 and 6 system cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) rc_pin <= ~rc_pin;
    if (cyc % 3 == 2) xt_pin <= ~xt_pin;
  end

  wkt_top #(.WDT_BASE_CYCLES(BASE)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .internal_rc_clock(rc_pin), .xtal_clock(xt_pin),
    .irq(irq), .watchdog_overflow(watchdog_overflow));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg,
               seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    // No fixed wait: only the run timeout ends a hung access
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
    check(e, 1'b0, "write error");
    if (mdl.exists(idx)) mdl[idx] = d;
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [31:0] r);
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
    check(e, 1'b0, "read error");
    if (mdl.exists(idx)) check(r, mdl[idx], "register readback");
  endtask : rd

  // Bounded wait for irq or an overflow pulse; n is cycles waited
  task automatic wait_sig(input logic wd, input int lim, output int n);
    n = 0;
    while ((wd ? watchdog_overflow : irq) !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_sig

  // One interval; the config write clears the status flag and irq together, then two idle cycles
  task automatic tmr(input logic [7:0] cfg, input int p, output int t);
    int n;
    logic [31:0] v;
    t = $urandom_range(14, 10);
    wr(wkt_pkg::IDX_TGT_HIGH, 8'h00);
    wr(wkt_pkg::IDX_TGT_LOW, t[7:0]);
    wr(wkt_pkg::IDX_TMR_CFG, cfg);
    repeat (2) @(posedge clk_sys);
    wait_sig(1'b0, 400, n);
    check(n >= (t-1)*p-4 && n <= t*p+8, 1'b1, "interval length");
    rd(wkt_pkg::IDX_TMR_CFG, v);
    check(v[0], cfg[1], "enable after interval");
    rd(wkt_pkg::IDX_IRQ_STATUS, v);
    check(v[0], 1'b1, "interval flag");
  endtask : tmr

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v, a;
    logic e;
    int t, n, k;
    void'($urandom(32'h53e7a8c8));
    mdl[wkt_pkg::IDX_WDT_PERIOD] = 0;
    mdl[wkt_pkg::IDX_WDT_KEY] = 0;
    mdl[wkt_pkg::IDX_TGT_HIGH] = 0;
    mdl[wkt_pkg::IDX_TGT_LOW] = 0;
    mdl[wkt_pkg::IDX_IRQ_MASK] = 0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    foreach (mdl[i]) rd(i[7:0], v);
    rd(wkt_pkg::IDX_TMR_CFG, v);
    check(v, 32'h0, "config reset");
    rd(wkt_pkg::IDX_IRQ_STATUS, v);
    check(v, 32'h0, "status reset");
    wr(wkt_pkg::IDX_WDT_KEY, 8'h55);
    wr(wkt_pkg::IDX_IRQ_MASK, 8'h01);
    tmr(8'h01, 8, t);
    tmr(8'h05, 6, t);
    tmr(8'h07, 6, t);
    wr(wkt_pkg::IDX_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clk_sys);
    check(irq, 1'b0, "irq after flag clear");
    wait_sig(1'b0, 400, n);
    check(n <= t*6+8, 1'b1, "auto reload repeats");
    repeat (30) @(posedge clk_sys);
    wr(wkt_pkg::IDX_TMR_CFG, 8'h07);
    rd(wkt_pkg::IDX_CNT_LOW, v);
    check(v <= 1, 1'b1, "restart by enable");
    repeat (30) @(posedge clk_sys);
    wr(wkt_pkg::IDX_TGT_LOW, t[7:0]);
    rd(wkt_pkg::IDX_CNT_LOW, v);
    check(v <= 1, 1'b1, "restart by target");
    // Count ticks arriving while the enable is low are lost
    rd(wkt_pkg::IDX_CNT_LOW, a);
    clk_en <= 1'b0;
    repeat (40) @(posedge clk_sys);
    clk_en <= 1'b1;
    rd(wkt_pkg::IDX_CNT_LOW, v);
    check(v - a <= 1, 1'b1, "count frozen by clock enable");
    wr(wkt_pkg::IDX_TMR_CFG, 8'h00);
    rd(wkt_pkg::IDX_CNT_LOW, a);
    repeat (40) @(posedge clk_sys);
    rd(wkt_pkg::IDX_CNT_LOW, v);
    check(v, a, "stopped count");
    wr(wkt_pkg::IDX_TMR_CFG, 8'h0d);
    wait_sig(1'b0, 300, n);
    check(n, 300, "long step");
    wr(wkt_pkg::IDX_TMR_CFG, 8'h00);
    apb(1'b1, wkt_pkg::IDX_CNT_LOW, 8'h12, v, e);
    check(e, 1'b1, "count write refused");
    apb(1'b0, 8'h90, 8'h00, v, e);
    check(e, 1'b1, "unmapped read");
    k = $urandom_range(255, 0);
    if (k == 8'h55) k = 8'h56;
    wr(wkt_pkg::IDX_WDT_KEY, k[7:0]);
    for (int c = 0; c < 8; c++) begin
      wr(wkt_pkg::IDX_WDT_PERIOD, c[7:0]);
      wait_sig(1'b1, (BASE << c) + 20, n);
      @(posedge clk_sys);
      wait_sig(1'b1, (BASE << c) + 20, n);
      check(n >= (BASE << c) - 2 && n <= (BASE << c), 1'b1, "period");
    end
    rd(wkt_pkg::IDX_IRQ_STATUS, v);
    check(v[1], 1'b1, "watchdog flag");
    check(irq, 1'b0, "masked flag");
    wr(wkt_pkg::IDX_IRQ_MASK, 8'h03);
    repeat (2) @(posedge clk_sys);
    check(irq, 1'b1, "unmasked flag");
    wr(wkt_pkg::IDX_WDT_PERIOD, 8'h00);
    rd(wkt_pkg::IDX_IRQ_STATUS, v);
    check(v[1], 1'b0, "flag cleared by period write");
    check(irq, 1'b0, "irq after period write");
    // Shortest period now, so a watchdog that keeps running shows up
    wr(wkt_pkg::IDX_WDT_KEY, 8'h55);
    wait_sig(1'b1, 3*BASE, n);
    check(n, 3*BASE, "watchdog stopped");
    rd(wkt_pkg::IDX_IRQ_STATUS, v);
    check(v[1], 1'b0, "no flag while stopped");
    wrap_up;
  end

  // Watchdog run is about 51k cycles; allow 80k in all
  initial begin
    #1600000;
    error_cnt++;
    $display("mismatch at %0t: run timed out", $time);
    wrap_up;
  end
endmodule : testbench
